// file: common/apg_pkg.sv
package apg_pkg;
   // ****************************************************************
   // Register indices and byte addresses
   // ****************************************************************
   localparam logic [7:0] APG_IDX_SNAPSHOT = 8'h08;
   localparam logic [7:0] APG_IDX_PAIR45 = 8'h09;
   localparam logic [7:0] APG_IDX_PAIRS0123 = 8'h0a;
   localparam logic [7:0] APG_IDX_GAIN = 8'h0b;
   localparam int APG_ADDR_W = 8;
   localparam logic [7:0] APG_ADDR_SNAPSHOT = 8'(APG_IDX_SNAPSHOT * 4);
   localparam logic [7:0] APG_ADDR_PAIR45 = 8'(APG_IDX_PAIR45 * 4);
   localparam logic [7:0] APG_ADDR_PAIRS0123 = 8'(APG_IDX_PAIRS0123 * 4);
   localparam logic [7:0] APG_ADDR_GAIN = 8'(APG_IDX_GAIN * 4);

   // ****************************************************************
   // Field layout and values after reset
   // ****************************************************************
   localparam int APG_CHANNELS = 6;
   localparam int APG_COMP_W = 4;
   localparam int APG_CODE_W = 12;
   localparam int APG_AMP_W = 3;
   localparam int APG_PAIR_HI_LSB = 12;
   localparam logic [23:0] APG_SNAPSHOT_RST = 24'h333333;
   localparam logic [11:0] APG_CODE_RST = 12'h000;
   localparam logic [17:0] APG_GAIN_RST = 18'h00000;
   localparam logic [2:0] APG_AMP_MAX = 3'h5;
   localparam logic [1:0] APG_RESP_OKAY = 2'h0;
   localparam logic [1:0] APG_RESP_SLVERR = 2'h2;
endpackage

// file: rtl/apg_regs.sv
`timescale 1ns/1ps
module apg_regs
   import apg_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [23:0] comparator_in,
   input wire logic [5:0] converter_active,
   output logic [5:0] converter_restart,
   output logic [5:0] channel_run,
   output logic [17:0] amplifier_shift
);
   // ****************************************************************
   // Register storage
   // ****************************************************************
   logic [23:0] comparator_snapshot;
   logic [11:0] delay_code_pair45;
   logic [11:0] delay_code_pair23;
   logic [11:0] delay_code_pair01;
   logic [17:0] amplifier_setting;
   logic [11:0] delay_count [3];

   // ****************************************************************
   // Write channel: address and data may arrive in either order
   // ****************************************************************
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
   wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
   wire wr_fire = (aw_held | aw_take) & (w_held | w_take);
   wire sel_snap = wr_addr == APG_ADDR_SNAPSHOT;
   wire sel_p45 = wr_addr == APG_ADDR_PAIR45;
   wire sel_p0123 = wr_addr == APG_ADDR_PAIRS0123;
   wire sel_gain = wr_addr == APG_ADDR_GAIN;
   wire wr_hit = sel_snap | sel_p45 | sel_p0123 | sel_gain;
   // Byte enables widened to one mask bit per data bit.
   wire [23:0] wmask = {{8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   wire [23:0] wval = wr_data[23:0];
   wire phase_write = wr_fire & (sel_p45 | sel_p0123);

   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;

   // Hold whichever half came first until its partner turns up.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= APG_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         aw_held <= wr_fire ? 1'b0 : (aw_held | aw_take);
         w_held <= wr_fire ? 1'b0 : (w_held | w_take);
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? APG_RESP_OKAY : APG_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   wire [23:0] p45_in = {12'h000, delay_code_pair45};
   wire [23:0] p0123_in = {delay_code_pair23, delay_code_pair01};
   wire [23:0] gain_in = {6'h00, amplifier_setting};
   wire [23:0] p45_new = (p45_in & ~wmask) | (wval & wmask);
   wire [23:0] p0123_new = (p0123_in & ~wmask) | (wval & wmask);
   wire [23:0] gain_new = (gain_in & ~wmask) | (wval & wmask);
   wire [23:0] snap_new = (comparator_snapshot & ~wmask) | (wval & wmask);

   always_ff @(posedge clock) begin
      if (!rstn) begin
         delay_code_pair45 <= APG_CODE_RST;
         delay_code_pair23 <= APG_CODE_RST;
         delay_code_pair01 <= APG_CODE_RST;
         amplifier_setting <= APG_GAIN_RST;
      end else if (wr_fire) begin
         if (sel_p45) begin
            delay_code_pair45 <= p45_new[11:0];
         end
         if (sel_p0123) begin
            delay_code_pair23 <= p0123_new[23:12];
            delay_code_pair01 <= p0123_new[11:0];
         end
         if (sel_gain) begin
            amplifier_setting <= gain_new[17:0];
         end
      end
   end

   // A software write lands for one period only; the modulator overwrites
   // it on the next edge, which is why writing it upsets accuracy.
   // per-period refresh
   always_ff @(posedge clock) begin
      if (!rstn) begin
         comparator_snapshot <= APG_SNAPSHOT_RST;
      end else if (wr_fire & sel_snap) begin
         comparator_snapshot <= snap_new;
      end else begin
         comparator_snapshot <= comparator_in;
      end
   end

   // ****************************************************************
   // Read channel
   // ****************************************************************
   wire rd_snap = s_axi_araddr == APG_ADDR_SNAPSHOT;
   wire rd_p45 = s_axi_araddr == APG_ADDR_PAIR45;
   wire rd_p0123 = s_axi_araddr == APG_ADDR_PAIRS0123;
   wire rd_gain = s_axi_araddr == APG_ADDR_GAIN;
   wire rd_hit = rd_snap | rd_p45 | rd_p0123 | rd_gain;
   wire [23:0] rd_val = ({24{rd_snap}} & comparator_snapshot)
                      | ({24{rd_p45}} & p45_in)
                      | ({24{rd_p0123}} & p0123_in)
                      | ({24{rd_gain}} & gain_in);
   wire ar_take = s_axi_arvalid & s_axi_arready;

   assign s_axi_arready = ~s_axi_rvalid;

   // Unmapped reads return zero with a slave error.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= APG_RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {8'h00, rd_val};
         s_axi_rresp <= rd_hit ? APG_RESP_OKAY : APG_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // Converter restart and phase delay sequencing
   // ****************************************************************
   wire [11:0] pair_code [3];
   assign pair_code[0] = delay_code_pair01;
   assign pair_code[1] = delay_code_pair23;
   assign pair_code[2] = delay_code_pair45;
   logic [5:0] next_run;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         converter_restart <= 6'h00;
         channel_run <= 6'h00;
      end else begin
         converter_restart <= phase_write ? converter_active : 6'h00;
         channel_run <= next_run;
      end
   end

   // Codes are already stored by the restart cycle, so the counters
   // load the new delays, not the previous ones.
   for (genvar i = 0; i < 3; i++) begin : g_pair
      always_ff @(posedge clock) begin
         if (!rstn) begin
            delay_count[i] <= APG_CODE_RST;
         end else if (|converter_restart) begin
            delay_count[i] <= pair_code[i];
         end else if (delay_count[i] != 12'h000) begin
            delay_count[i] <= delay_count[i] - 12'h001;
         end
      end
      assign next_run[2*i+1] = converter_active[2*i+1] & ~|converter_restart;
      assign next_run[2*i] = converter_active[2*i] & ~|converter_restart
                           & (delay_count[i] == 12'h000);
   end

   // ****************************************************************
   // Amplifier code decode
   // ****************************************************************
   for (genvar c = 0; c < APG_CHANNELS; c++) begin : g_amp
      wire [2:0] code = amplifier_setting[3*c +: 3];
      assign amplifier_shift[3*c +: 3] = (code > APG_AMP_MAX) ? 3'h0 : code;
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   a_snap_refresh: assert property (
      !(wr_fire & sel_snap) |=> comparator_snapshot == $past(comparator_in))
      else $error("Snapshot missed a modulator refresh.");
   a_snap_readback: assert property (
      ar_take & rd_snap |=>
         s_axi_rdata[23:20] == $past(comparator_snapshot[23:20])
         && s_axi_rdata[3:0] == $past(comparator_snapshot[3:0]))
      else $error("Snapshot channel nibbles read back wrong.");
   a_phase_restart: assert property (
      phase_write |=> converter_restart == $past(converter_active)
         ##1 channel_run == 6'h00)
      else $error("Phase write did not restart active converters.");
   a_pair45_store: assert property (
      wr_fire & sel_p45 & (&wr_strb[1:0]) |=>
         delay_code_pair45 == $past(wr_data[11:0]))
      else $error("Pair 4/5 code not stored.");
   a_pair45_upper: assert property (
      ar_take & rd_p45 |=> s_axi_rdata[31:12] == 20'h0)
      else $error("Pair 4/5 upper bits not zero.");
   a_shared_fields: assert property (
      wr_fire & sel_p0123 & (&wr_strb[2:0]) |=>
         delay_code_pair23 == $past(wr_data[23:12])
         && delay_code_pair01 == $past(wr_data[11:0]))
      else $error("Shared phase fields stored wrong.");
   a_gain_upper: assert property (
      ar_take & rd_gain |=> s_axi_rdata[31:18] == 14'h0)
      else $error("Gain upper bits not zero.");
   a_gain_reserved: assert property (
      amplifier_setting[17:16] == 2'h3 |-> amplifier_shift[17:15] == 3'h0)
      else $error("Reserved gain code not unity.");
   a_gain_legal: assert property (
      amplifier_setting[2:0] <= APG_AMP_MAX |->
         amplifier_shift[2:0] == amplifier_setting[2:0])
      else $error("Legal gain code mapped wrong.");
   a_delay_hold: assert property (
      (|converter_restart) && delay_code_pair23 == 12'h003 |=>
         ##1 !channel_run[2] [*3] ##1 channel_run[2] == converter_active[2])
      else $error("Channel 2 start not delayed by its code.");
   // Each pair's non-reference start against its programmed code.
   a_pair01_start: assert property (
      (|converter_restart) && delay_code_pair01 == 12'h007 |=>
         ##7 !channel_run[0] ##1 channel_run[0] == $past(converter_active[0]))
      else $error("Channel 0 start not delayed by its code.");
   a_pair45_start: assert property (
      (|converter_restart) && delay_code_pair45 == 12'h005 |=>
         ##5 !channel_run[4] ##1 channel_run[4] == $past(converter_active[4]))
      else $error("Channel 4 start not delayed by its code.");
   a_ref_start: assert property (
      (|converter_restart) |=> ##1 channel_run[5] == $past(converter_active[5]))
      else $error("Reference channel did not restart on time.");
   // The reset value only stands one cycle, so it is caught at release.
   a_snap_reset: assert property (
      $rose(rstn) |-> comparator_snapshot == APG_SNAPSHOT_RST)
      else $error("Snapshot did not start at the zero-volt value.");
   a_restart_pulse: assert property (
      (|converter_restart) |=> converter_restart == 6'h00)
      else $error("Converter restart lasted more than one cycle.");

   c_phase_write: cover property (phase_write);
   c_delayed_start: cover property (
      (|converter_restart) ##[2:40] $rose(channel_run[0]));
   c_unmapped_read: cover property (
      s_axi_rvalid && s_axi_rresp == APG_RESP_SLVERR);
   c_reserved_gain: cover property (amplifier_setting[17:15] == 3'h7);
   c_all_restart: cover property (converter_restart == 6'h3f);
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import apg_pkg::*;
;
   // ****************************************************************
   // Stimulus signals and bookkeeping
   // ****************************************************************
   logic clock, rstn;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [23:0] comparator_in;
   logic [5:0] converter_active, converter_restart, channel_run, prev_run;
   logic [5:0] last_restart;
   logic [17:0] amplifier_shift, g, sh;
   int n_errors = 0, total_checks = 0, cyc = 0, n_restart = 0, r0;
   int rise [6];
   int gains [8] = '{1, 2, 4, 8, 16, 32, 1, 1}; // Reserved codes are unity.

   apg_regs u_apg_regs (.clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .comparator_in(comparator_in), .converter_active(converter_active),
      .converter_restart(converter_restart), .channel_run(channel_run),
      .amplifier_shift(amplifier_shift));

   // The clock toggles every half period of 5 ns.
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Cycle count, hang guard and stamps of each channel's run start.
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         results();
      end
      prev_run <= channel_run;
      for (int i = 0; i < 6; i++) begin
         if (channel_run[i] && !prev_run[i]) begin
            rise[i] <= cyc;
         end
      end
      if (|converter_restart) begin
         last_restart <= converter_restart;
         n_restart <= n_restart + 1;
      end
   end

   // ****************************************************************
   // Bus tasks and comparison
   // ****************************************************************
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask

   // Each channel is released only at the edge where it is taken.
   // Each call first lets an edge pass, so no signal is set twice at once.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(32'(bresp), 32'(er));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata, e);
      chk(32'(rresp), 32'(er));
   endtask

   task automatic results();
      if (n_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      rstn <= 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
      awaddr <= 8'h00;
      araddr <= 8'h00;
      wdata <= 32'h0;
      comparator_in <= APG_SNAPSHOT_RST;
      converter_active <= 6'h2d;
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      // Values after reset, snapshot meaning zero volts everywhere.
      rd(APG_ADDR_SNAPSHOT, 32'h333333, APG_RESP_OKAY);
      rd(APG_ADDR_PAIR45, 32'h0, APG_RESP_OKAY);
      rd(APG_ADDR_PAIRS0123, 32'h0, APG_RESP_OKAY);
      rd(APG_ADDR_GAIN, 32'h0, APG_RESP_OKAY);
      // snapshot never written
      // The snapshot follows the comparators every cycle.
      comparator_in <= 24'h123456;
      @(posedge clock);
      comparator_in <= 24'hfedcba;
      repeat (3) @(posedge clock);
      rd(APG_ADDR_SNAPSHOT, 32'hfedcba, APG_RESP_OKAY);
      // A phase write restarts exactly the active converters.
      r0 = n_restart;
      wr(APG_ADDR_PAIRS0123, 32'hff003007, APG_RESP_OKAY);
      repeat (30) @(posedge clock);
      chk(32'(n_restart - r0), 32'h1);
      chk(32'(last_restart), 32'h2d);
      rd(APG_ADDR_PAIRS0123, 32'h003007, APG_RESP_OKAY);
      converter_active <= 6'h3f;
      wr(APG_ADDR_PAIR45, 32'hfffff005, APG_RESP_OKAY);
      repeat (30) @(posedge clock);
      chk(32'(n_restart - r0), 32'h2);
      chk(32'(last_restart), 32'h3f);
      rd(APG_ADDR_PAIR45, 32'h000005, APG_RESP_OKAY);
      // Non-reference channels start the coded periods after the reference.
      chk(32'(rise[4] - rise[5]), 32'h5);
      chk(32'(rise[2] - rise[3]), 32'h3);
      chk(32'(rise[0] - rise[1]), 32'h7);
      // Every amplifier code on every channel, reserved upper bits set.
      for (int c = 0; c < 8; c++) begin
         for (int n = 0; n < 6; n++) begin
            g[3*n+:3] = 3'((c + n) % 8);
            // The shift is the base-two logarithm of the coded gain.
            sh[3*n+:3] = 3'($clog2(gains[g[3*n+:3]]));
         end
         wr(APG_ADDR_GAIN, {8'hff, 6'h3f, g}, APG_RESP_OKAY);
         rd(APG_ADDR_GAIN, {14'h0, g}, APG_RESP_OKAY);
         chk(32'(amplifier_shift), 32'(sh));
      end
      // Unmapped places answer with an error and read zero.
      wr(8'h04, 32'h1, APG_RESP_SLVERR);
      rd(8'h30, 32'h0, APG_RESP_SLVERR);
      results();
   end
endmodule
